// ### grpb_pkg.sv
package grpb_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned S_PER_MIN = 60;
    localparam int unsigned TICK_CYC_DEF = CLK_HZ / MS_PER_S;
    localparam int unsigned MSERR_S = 15;
    localparam int unsigned NOPPS_S = 6;
    localparam int unsigned NOACT_MIN = 30;
    localparam int unsigned MSERR_MS_DEF = MSERR_S * MS_PER_S;
    localparam int unsigned NOPPS_MS_DEF = NOPPS_S * MS_PER_S;
    localparam int unsigned NOACT_MS_DEF = NOACT_MIN * S_PER_MIN * MS_PER_S;
    localparam int unsigned DIV_W = 15;
    localparam int unsigned MSC_W = 21;
    localparam logic [7:0] MSERR_SVS = 8'h02;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [9:0] ADR_CTRL = 10'h000;
    localparam logic [9:0] ADR_STAT = 10'h008;
    localparam logic [9:0] ADR_MEM_LO = 10'h100;
    localparam logic [9:0] ADR_MEM_HI = 10'h1fc;
    localparam int unsigned CTRL_AUTO_RAW = 0;
    localparam int unsigned CTRL_MULTI = 1;
    localparam int unsigned CTRL_AUTO_SEL = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_TRK_REF = 1;

    // ------------------------------------------------------------
    // packet identifiers, codes, byte positions
    // ------------------------------------------------------------
    localparam logic [7:0] ID_RAW = 8'h5a;
    localparam logic [7:0] ID_TRK = 8'h5d;
    localparam logic [7:0] ID_ERR = 8'h5f;
    localparam logic [7:0] ID_SEL = 8'h6c;
    localparam logic [7:0] ID_NMEA = 8'h7b;
    localparam logic [7:0] ERR_SUB = 8'h01;
    localparam logic [7:0] ERR_FUNC = 8'h0b;
    localparam logic [15:0] ERR_MSEC = 16'h0b03;
    localparam logic [15:0] ERR_WDOG = 16'h0b04;
    localparam logic [15:0] ERR_CPU = 16'h0b05;
    localparam logic [15:0] ERR_MSMULTI = 16'h0b06;
    localparam logic [15:0] ERR_NOCOMM = 16'h0b0a;
    localparam logic [15:0] ERR_NOACT = 16'h0b0d;
    localparam logic [15:0] ERR_NOPPS = 16'h0b0e;
    localparam logic [31:0] TDOP_ONE = 32'h3f80_0000;
    localparam logic [7:0] MSEC_MAX = 8'h04;
    localparam logic [5:0] B_SUB = 6'h01;
    localparam logic [5:0] B_FUNC = 6'h02;
    localparam logic [5:0] B_CHAN = 6'h02;
    localparam logic [5:0] B_RSV_HI = 6'h03;
    localparam logic [5:0] B_RSV_LO = 6'h04;
    localparam logic [5:0] B_CODE_HI = 6'h05;
    localparam logic [5:0] B_CODE_LO = 6'h06;
    localparam logic [5:0] B_FIX = 6'h01;
    localparam logic [5:0] B_TDOP = 6'h0e;
    localparam logic [5:0] B_NSV = 6'h12;
    localparam logic [5:0] B_SV0 = 6'h13;
    localparam logic [5:0] B_MSEC = 6'h16;
    localparam logic [5:0] B_USED = 6'h19;
    localparam logic [5:0] RAW_LAST = 6'h19;
    localparam logic [5:0] TRK_LAST = 6'h1a;
    localparam logic [5:0] ERR_LAST = 6'h19;
    localparam logic [5:0] SEL_MAX_SV = 6'h2d;
    localparam int unsigned MEM_AW = 6;
    localparam int unsigned MEM_DW = 9;

    typedef enum logic [2:0] {
        K_ERR = 3'h0,
        K_TRK = 3'h1,
        K_RAW = 3'h2,
        K_SEL = 3'h3,
        K_NMEA = 3'h4
    } grpb_kind_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RD = 2'b01,
        S_LD = 2'b11,
        S_SEND = 2'b10
    } grpb_state_t;

endpackage

// ### grpb_pay_mem.sv
module grpb_pay_mem
    import grpb_pkg::*;
(
    input logic clk_i,
    input logic rst_i,
    input logic we_i,
    input logic [MEM_AW-1:0] waddr_i,
    input logic [MEM_DW-1:0] wdata_i,
    input logic [MEM_AW-1:0] raddr_i,
    output logic [MEM_DW-1:0] rdata_o
);

    // no reset on the array: software fills it before each request
    logic [MEM_DW-1:0] mem_r [2**MEM_AW];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_r[raddr_i];
        end
    end

endmodule

// ### grpb_fault_mon.sv
module grpb_fault_mon
    import grpb_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYC_DEF,
    parameter int unsigned MSERR_MS = MSERR_MS_DEF,
    parameter int unsigned NOPPS_MS = NOPPS_MS_DEF,
    parameter int unsigned NOACT_MS = NOACT_MS_DEF,
    parameter bit ACT_CHECK = 1'b1
) (
    input logic clk_i,
    input logic rst_i,
    input logic [7:0] ms_err_svs_i,
    input logic pps_i,
    input logic comm_ok_i,
    input logic active_i,
    output logic fault_o,
    output logic [15:0] code_o
);

    logic [DIV_W-1:0] div_r;
    logic tick_r;
    logic [MSC_W-1:0] mse_r;
    logic [MSC_W-1:0] pps_r;
    logic [MSC_W-1:0] act_r;
    logic seen_r;
    logic comm_q_r;
    logic mse_bad;
    logic mse_hit;
    logic pps_hit;
    logic act_hit;
    logic comm_hit;

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || div_r == DIV_W'(TICK_CYC - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        tick_r <= !rst_i && div_r == DIV_W'(TICK_CYC - 1);
    end

    // ------------------------------------------------------------
    // supervision timers
    // ------------------------------------------------------------
    assign mse_bad = ms_err_svs_i > MSERR_SVS;
    assign mse_hit = tick_r && mse_bad && mse_r == MSC_W'(MSERR_MS - 1); // R10
    assign pps_hit = tick_r && !pps_i && pps_r == MSC_W'(NOPPS_MS - 1); // R12
    assign act_hit = ACT_CHECK && tick_r && !seen_r && act_r == MSC_W'(NOACT_MS - 1); // R11
    assign comm_hit = comm_q_r && !comm_ok_i; // R11

    always_ff @(posedge clk_i) begin
        if (rst_i || !mse_bad || mse_hit) begin
            mse_r <= '0;
        end else if (tick_r) begin
            mse_r <= mse_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || pps_i || pps_hit) begin
            pps_r <= '0;
        end else if (tick_r) begin
            pps_r <= pps_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_r <= '0;
            seen_r <= 1'b0;
        end else begin
            seen_r <= seen_r || active_i || act_hit;
            if (tick_r) begin
                act_r <= act_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comm_q_r <= 1'b0;
            fault_o <= 1'b0;
            code_o <= '0;
        end else begin
            comm_q_r <= comm_ok_i;
            fault_o <= mse_hit || pps_hit || act_hit || comm_hit;
            if (comm_hit) begin
                code_o <= ERR_NOCOMM; // R11
            end else if (mse_hit) begin
                code_o <= ERR_MSMULTI; // R10
            end else if (pps_hit) begin
                code_o <= ERR_NOPPS; // R12
            end else if (act_hit) begin
                code_o <= ERR_NOACT; // R11
            end
        end
    end

endmodule

// ### grpb_report_builder.sv
// Summary of operation
// R1: raw measurement report on host request, or on each measurement when auto enabled.
// R2: sample length float at bytes 2-5 gives averaging interval in milliseconds.
// R3: code phase float at bytes 10-13 in sixteenths of a chip.
// R4: tracking status report only answered while multi-constellation mode is set.
// R5: tracking byte 2 carries channel index minus one.
// R6: tracking byte 22 is millisecond-ambiguity state 0 to 4.
// R7: tracking byte 25: bit0 timing use, bit1 position use, rest zero.
// R8: after every reset send reset error report with id, sub-code, function, zeros.
// R9: error code bytes 5-6 tell millisecond error, watchdog or overload.
// R10: code for millisecond errors on over two satellites beyond fifteen seconds.
// R11: codes for lost subsystem link and, on one variant, no active mode in 30 min.
// R12: code when no pulse-per-second seen for six seconds.
// R13: selection list length grows with number of satellites used.
// R14: satellites rejected by integrity monitor are sent as negative identifiers.
// R15: selection list sent on request and optionally automatically.
// R16: selection byte 1: fix dimension bits 0-2, fix mode bit 3.
// R17: dilution figures as floats at bytes 2-5, 6-9, 10-13, 14-17.
// R18: time dilution field always holds float one.
// R19: byte 18 holds satellite count, identifiers follow from byte 19.
// R20: sentence-output configuration echoed with identical data layout.
// R21: multi-byte fields go out most significant byte first, standard floats.
// R22: reserved bits and bytes are sent as zero.
module grpb_report_builder
    import grpb_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYC_DEF,
    parameter int unsigned MSERR_MS = MSERR_MS_DEF,
    parameter int unsigned NOPPS_MS = NOPPS_MS_DEF,
    parameter int unsigned NOACT_MS = NOACT_MS_DEF,
    parameter bit ACT_CHECK = 1'b1
) (
    input logic clk_i,
    input logic rst_i,
    input logic [9:0] wb_adr_i,
    input logic [31:0] wb_dat_i,
    input logic [3:0] wb_sel_i,
    input logic wb_we_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input logic raw_req_i,
    input logic trk_req_i,
    input logic sel_req_i,
    input logic nmea_req_i,
    input logic meas_rdy_i,
    input logic fix_rdy_i,
    input logic [15:0] reset_cause_i,
    input logic [7:0] ms_err_svs_i,
    input logic pps_i,
    input logic comm_ok_i,
    input logic active_i,
    output logic [7:0] out_data_o,
    output logic out_valid_o,
    output logic out_sop_o,
    output logic out_eop_o,
    input logic out_ready_i,
    output logic fault_req_o,
    output logic [15:0] fault_code_o
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_mem(input logic [9:0] adr);
        return adr >= ADR_MEM_LO && adr <= ADR_MEM_HI;
    endfunction

    function automatic logic [7:0] pkt_id(input grpb_kind_t k);
        case (k)
            K_ERR: return ID_ERR;
            K_TRK: return ID_TRK;
            K_RAW: return ID_RAW;
            K_SEL: return ID_SEL;
            default: return ID_NMEA;
        endcase
    endfunction

    function automatic logic [7:0] pkt_byte(
        input grpb_kind_t k,
        input logic [5:0] i,
        input logic [8:0] d,
        input logic [15:0] code,
        input logic [5:0] nsv
    );
        logic [7:0] b;
        b = d[7:0];
        if (i == '0) begin
            b = pkt_id(k);
        end else begin
            case (k)
                K_ERR: begin
                    if (i == B_SUB) b = ERR_SUB; // R8
                    else if (i == B_FUNC) b = ERR_FUNC; // R8
                    else if (i == B_RSV_HI || i == B_RSV_LO) b = '0; // R8 R22
                    else if (i == B_CODE_HI) b = code[15:8]; // R9 R21
                    else if (i == B_CODE_LO) b = code[7:0]; // R9 R21
                end
                K_TRK: begin
                    if (i == B_CHAN) b = d[7:0] - 8'h01; // R5
                    else if (i == B_MSEC) b = (d[7:0] > MSEC_MAX) ? MSEC_MAX : d[7:0]; // R6
                    else if (i == B_USED) b = {6'h00, d[1:0]}; // R7 R22
                end
                K_SEL: begin
                    if (i == B_FIX) b = {4'h0, d[3:0]}; // R16 R22
                    else if (i >= B_TDOP && i < B_NSV) begin
                        b = TDOP_ONE[8 * (3 - 32'(i - B_TDOP)) +: 8]; // R18 R21
                    end else if (i == B_NSV) b = {2'b00, nsv}; // R19
                    else if (i >= B_SV0) b = d[8] ? (~d[7:0] + 8'h01) : d[7:0]; // R14 R19
                end
                default: b = d[7:0]; // R2 R3 R17 R20 R21
            endcase
        end
        return b;
    endfunction

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] ctrl_r;
    logic trk_ref_r;
    logic armed_r;
    logic [15:0] cause_r;
    logic [4:0] pend_r;
    logic [4:0] take;
    logic [4:0] set_v;
    grpb_state_t st_r;
    grpb_kind_t kind_r;
    logic [5:0] idx_r;
    logic [5:0] last_r;
    logic [5:0] nsv_r;
    logic [8:0] rd_q;
    logic bus_hit;
    logic bus_wr;
    logic mem_we;
    logic [5:0] nsv_cfg;
    logic [5:0] nmea_len;
    logic fault_w;
    logic [15:0] fcode_w;

    assign bus_hit = wb_cyc_i && wb_stb_i && !ack_r;
    assign bus_wr = bus_hit && wb_we_i;
    assign mem_we = bus_wr && is_mem(wb_adr_i) && wb_sel_i[0];
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    // count beyond the buffer would overrun it, so it is clamped
    assign nsv_cfg = (ctrl_r[21:16] > SEL_MAX_SV) ? SEL_MAX_SV : ctrl_r[21:16];
    assign nmea_len = ctrl_r[13:8];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
        end else if (bus_wr && wb_adr_i == ADR_CTRL) begin
            if (wb_sel_i[0]) ctrl_r[7:0] <= {5'h00, wb_dat_i[2:0]};
            if (wb_sel_i[1]) ctrl_r[15:8] <= {2'b00, wb_dat_i[13:8]};
            if (wb_sel_i[2]) ctrl_r[23:16] <= {2'b00, wb_dat_i[21:16]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= '0;
        end else if (!bus_hit || wb_we_i) begin
            dat_r <= '0;
        end else if (wb_adr_i == ADR_CTRL) begin
            dat_r <= ctrl_r;
        end else if (wb_adr_i == ADR_STAT) begin
            dat_r <= {cause_r, 3'h0, pend_r, 6'h00, trk_ref_r, st_r != S_IDLE};
        end else begin
            dat_r <= '0;
        end
    end

    // refused tracking request stays flagged until software writes one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trk_ref_r <= 1'b0;
        end else if (trk_req_i && !ctrl_r[CTRL_MULTI]) begin
            trk_ref_r <= 1'b1; // R4
        end else if (bus_wr && wb_adr_i == ADR_STAT && wb_sel_i[0]
                     && wb_dat_i[STAT_TRK_REF]) begin
            trk_ref_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // reset cause and fault code capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_r <= 1'b1;
            cause_r <= '0;
        end else if (armed_r) begin
            armed_r <= 1'b0;
            cause_r <= reset_cause_i; // R9
        end else if (fault_w && !pend_r[K_ERR] && (st_r == S_IDLE || kind_r != K_ERR)) begin
            cause_r <= fcode_w;
        end
    end

    grpb_fault_mon #(
        .TICK_CYC(TICK_CYC),
        .MSERR_MS(MSERR_MS),
        .NOPPS_MS(NOPPS_MS),
        .NOACT_MS(NOACT_MS),
        .ACT_CHECK(ACT_CHECK)
    ) u_mon (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ms_err_svs_i(ms_err_svs_i),
        .pps_i(pps_i),
        .comm_ok_i(comm_ok_i),
        .active_i(active_i),
        .fault_o(fault_w),
        .code_o(fcode_w)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_req_o <= 1'b0;
            fault_code_o <= '0;
        end else begin
            fault_req_o <= fault_w; // R10 R11 R12
            fault_code_o <= fcode_w;
        end
    end

    // ------------------------------------------------------------
    // report requests
    // ------------------------------------------------------------
    always_comb begin
        set_v = '0;
        set_v[K_TRK] = trk_req_i && ctrl_r[CTRL_MULTI]; // R4
        set_v[K_RAW] = raw_req_i || (meas_rdy_i && ctrl_r[CTRL_AUTO_RAW]); // R1
        set_v[K_SEL] = sel_req_i || (fix_rdy_i && ctrl_r[CTRL_AUTO_SEL]); // R15
        set_v[K_NMEA] = nmea_req_i; // R20
    end

    always_comb begin
        take = '0;
        if (st_r == S_IDLE && !armed_r) begin
            for (int k = 4; k >= 0; k--) begin
                if (pend_r[k]) take = 5'(1 << k);
            end
        end
    end

    // a request arriving while its flag is taken stays pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 5'h01; // R8
        end else begin
            pend_r <= (pend_r & ~take) | set_v;
        end
    end

    // ------------------------------------------------------------
    // byte serializer
    // ------------------------------------------------------------
    grpb_pay_mem u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(mem_we),
        .waddr_i(wb_adr_i[7:2]),
        .wdata_i({wb_dat_i[8], wb_dat_i[7:0]}),
        .raddr_i(idx_r),
        .rdata_o(rd_q)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= S_IDLE;
            kind_r <= K_ERR;
            idx_r <= '0;
            last_r <= '0;
            nsv_r <= '0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    idx_r <= '0;
                    if (take != '0) begin
                        st_r <= S_RD;
                        nsv_r <= nsv_cfg;
                        if (take[K_ERR]) begin
                            kind_r <= K_ERR;
                            last_r <= ERR_LAST;
                        end else if (take[K_TRK]) begin
                            kind_r <= K_TRK;
                            last_r <= TRK_LAST;
                        end else if (take[K_RAW]) begin
                            kind_r <= K_RAW;
                            last_r <= RAW_LAST;
                        end else if (take[K_SEL]) begin
                            kind_r <= K_SEL;
                            last_r <= B_NSV + nsv_cfg; // R13
                        end else begin
                            kind_r <= K_NMEA;
                            last_r <= (nmea_len == '0) ? '0 : nmea_len - 6'h01;
                        end
                    end
                end
                S_RD: st_r <= S_LD;
                S_LD: st_r <= S_SEND;
                default: begin
                    if (out_ready_i) begin
                        if (idx_r == last_r) begin
                            st_r <= S_IDLE;
                        end else begin
                            idx_r <= idx_r + 6'h01;
                            st_r <= S_RD;
                        end
                    end
                end
            endcase
        end
    end

    // three cycles per byte: simple, and far faster than any serial line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_data_o <= '0;
            out_valid_o <= 1'b0;
            out_sop_o <= 1'b0;
            out_eop_o <= 1'b0;
        end else if (st_r == S_LD) begin
            out_data_o <= pkt_byte(kind_r, idx_r, rd_q, cause_r, nsv_r);
            out_valid_o <= 1'b1;
            out_sop_o <= idx_r == '0;
            out_eop_o <= idx_r == last_r;
        end else if (st_r == S_SEND && out_ready_i) begin
            out_valid_o <= 1'b0;
            out_sop_o <= 1'b0;
            out_eop_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_err_first: assert property ($fell(rst_i) |-> ##[1:6] (out_valid_o && out_sop_o
        && out_data_o == ID_ERR)) else $error("no error report after reset"); // R8
    a_trk_refused: assert property (trk_req_i && !ctrl_r[CTRL_MULTI] |=> trk_ref_r
        && !pend_r[K_TRK]) else $error("tracking request not refused"); // R4
    a_raw_auto: assert property (meas_rdy_i && ctrl_r[CTRL_AUTO_RAW] |=> pend_r[K_RAW]
        || kind_r == K_RAW) else $error("auto raw report lost"); // R1
    a_tdop_one: assert property (out_valid_o && kind_r == K_SEL && idx_r == B_TDOP
        |-> out_data_o == TDOP_ONE[31:24]) else $error("tdop not one"); // R18
    a_chan_minus: assert property (out_valid_o && kind_r == K_TRK && idx_r == B_CHAN
        |-> out_data_o == rd_q[7:0] - 8'h01) else $error("channel not minus one"); // R5
    a_used_rsvd: assert property (out_valid_o && kind_r == K_TRK && idx_r == B_USED
        |-> out_data_o[7:2] == '0) else $error("used flags reserved set"); // R7
    a_msec_range: assert property (out_valid_o && kind_r == K_TRK && idx_r == B_MSEC
        |-> out_data_o <= MSEC_MAX) else $error("msec state out of range"); // R6
    a_sv_negate: assert property (out_valid_o && kind_r == K_SEL && idx_r >= B_SV0
        && rd_q[8] |-> out_data_o + rd_q[7:0] == 8'h00) else $error("rejected not negative"); // R14
    a_sel_len: assert property (out_eop_o && out_valid_o && kind_r == K_SEL
        |-> idx_r == B_NSV + nsv_r) else $error("selection length wrong"); // R13
    a_hold_byte: assert property (out_valid_o && !out_ready_i |=> out_valid_o
        && $stable(out_data_o)) else $error("byte dropped under stall");
    a_ack_pulse: assert property (ack_r |=> !ack_r) else $error("ack held");

    c_raw_pkt: cover property (out_valid_o && out_eop_o && kind_r == K_RAW && out_ready_i);
    c_sel_pkt: cover property (out_valid_o && out_eop_o && kind_r == K_SEL && out_ready_i);
    c_trk_ref: cover property (trk_req_i && !ctrl_r[CTRL_MULTI]);
    c_fault: cover property (fault_req_o);

endmodule

// ### grpb_host_sink.sv
// ------------------------------------------------------------
// host side: takes report bytes with random stalls
// ------------------------------------------------------------
module grpb_host_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] data_i,
    input wire logic valid_i,
    input wire logic sop_i,
    input wire logic eop_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] q[$];
    int sd = 32'h4220;
    initial ready_o = 1'b0;
    // random stalls stretch about one byte in four so the held-valid path is exercised
    always @(posedge clk_i) begin
        if (valid_i && ready_o && !rst_i) q.push_back({eop_i, sop_i, data_i});
        ready_o <= !rst_i && ($random(sd) % 4 != 0);
    end
endmodule

// ### testbench.sv
// ------------------------------------------------------------
// report builder bench
// ------------------------------------------------------------
module testbench import grpb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, rdy, vld, sop, eop, frq;
    logic pps = 0, cok = 1, act = 0;
    logic [9:0] adr = 0;
    logic [31:0] wdat = 0, rdat, r;
    logic [5:0] req = 0;
    logic [7:0] od, mse = 0;
    logic [15:0] fc, rc = ERR_WDOG;
    int err_total = 0, n_compared = 0, seed = 32'h4220, m[64];
    int e[$];
    bit fs[int];
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (frq === 1'b1) fs[int'(fc)] = 1'b1;
    grpb_report_builder #(.TICK_CYC(10), .MSERR_MS(5), .NOPPS_MS(4), .NOACT_MS(6)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .raw_req_i(req[0]), .trk_req_i(req[1]), .sel_req_i(req[2]), .nmea_req_i(req[3]),
        .meas_rdy_i(req[4]), .fix_rdy_i(req[5]), .reset_cause_i(rc), .ms_err_svs_i(mse),
        .pps_i(pps), .comm_ok_i(cok), .active_i(act), .out_data_o(od), .out_valid_o(vld),
        .out_sop_o(sop), .out_eop_o(eop), .out_ready_i(rdy), .fault_req_o(frq),
        .fault_code_o(fc));
    grpb_host_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .data_i(od), .valid_i(vld),
        .sop_i(sop), .eop_i(eop), .ready_o(rdy));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask
    task wb(input logic [9:0] a, input logic [31:0] d, input logic w);
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        we <= w;
        cyc <= 1;
        stb <= 1;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task wm(input int i, input int v);
        wb(10'h100 + 10'(4 * i), 32'(v), 1'b1);
        m[i] = v;
    endtask
    task pulse(input int b);
        @(posedge clk_i);
        req[b] <= 1'b1;
        @(posedge clk_i);
        req[b] <= 1'b0;
    endtask
    // negative entries are bytes whose value is not defined here
    task pkt;
        wait (sink_u.q.size() >= e.size());
        foreach (e[i]) begin
            if (e[i] >= 0) chk("byte", 32'(sink_u.q[0][7:0]), e[i]);
            chk("framing", 32'(sink_u.q[0][9:8]), {i == e.size() - 1, i == 0});
            void'(sink_u.q.pop_front());
        end
        e = {};
    endtask
    task final_report;
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        e = {ID_ERR, ERR_SUB, ERR_FUNC, 0, 0, ERR_WDOG[15:8], ERR_WDOG[7:0]};
        repeat (19) e.push_back(-1);
        pkt();
        for (int i = 1; i < 27; i++) wm(i, {$random(seed)} % 256);
        for (int k = 0; k < 2; k++) begin
            wb(ADR_CTRL, 32'(k), 1'b1);
            e = {ID_RAW};
            for (int i = 1; i < 26; i++) e.push_back(m[i]);
            pulse(k * 4);
            pkt();
        end
        wb(ADR_CTRL, 32'h0, 1'b1);
        pulse(1);
        repeat (30) @(posedge clk_i);
        chk("refused packet", sink_u.q.size(), 0);
        wb(ADR_STAT, 32'h0, 1'b0);
        chk("refused flag", r[STAT_TRK_REF], 1);
        wm(2, 5);
        wm(22, 9);
        wm(25, 8'hff);
        wb(ADR_CTRL, 32'h2, 1'b1);
        e = {ID_TRK};
        for (int i = 1; i < 27; i++) e.push_back(i == 2 ? 4 : i == 22 ? 4 : i == 25 ? 3 : m[i]);
        pulse(1);
        pkt();
        wm(1, 8'hf5);
        wm(19, 9'h105);
        wm(20, 8'hd0);
        for (int k = 0; k < 2; k++) begin
            wb(ADR_CTRL, 32'h0002_0000 | 32'(k * 4), 1'b1);
            e = {ID_SEL, 5};
            for (int i = 2; i < 14; i++) e.push_back(m[i]);
            e = {e, 8'h3f, 8'h80, 0, 0, 2, 8'hfb, 8'hd0};
            pulse(2 + k * 3);
            pkt();
        end
        wb(ADR_CTRL, 32'h0000_0400, 1'b1);
        e = {ID_NMEA, m[1], m[2], m[3]};
        pulse(3);
        pkt();
        wb(10'h04c, 32'h0, 1'b0);
        chk("unmapped", r, 0);
        chk("fault code", fc, ERR_NOPPS);
        pps <= 1'b1;
        mse <= 8'h03;
        repeat (80) @(posedge clk_i);
        chk("fault code", fc, ERR_MSMULTI);
        mse <= 8'h00;
        cok <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("fault code", fc, ERR_NOCOMM);
        chk("fault noact", fs.exists(int'(ERR_NOACT)), 1);
        chk("fault nopps", fs.exists(int'(ERR_NOPPS)), 1);
        final_report();
    end
    // the whole sequence needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        final_report();
    end
endmodule
